// ==== src/tcu_regs.svh ====
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH

// Register indices; byte address is four times the index
`define TCU_IDX_CFG1     16'hA050
`define TCU_IDX_CFG2     16'hA051
`define TCU_IDX_CFG3     16'hA052
`define TCU_IDX_PRDL     16'hA054
`define TCU_IDX_PRDH     16'hA055
`define TCU_IDX_CMPL     16'hA056
`define TCU_IDX_CMPH     16'hA057
`define TCU_IDX_STAT     16'hA058
`define TCU_IDX_MASK     16'hA059
`define TCU_IDX_CPRL     16'hA060
`define TCU_IDX_CPRH     16'hA061
`define TCU_IDX_CPFL     16'hA062
`define TCU_IDX_CPFH     16'hA063

// Field positions
`define TCU_CFG2_RSTTC   7
`define TCU_CFG2_TCPOL   3
`define TCU_CFG2_CCPOL   2
`define TCU_CFG2_TCF     1
`define TCU_CFG2_CCF     0
`define TCU_CFG3_SWCR    1
`define TCU_CFG3_SWCF    0

// Reset values
`define TCU_CFG_RST      8'h00
`define TCU_VAL_RST      16'h0000

// Output pulse widths in timer ticks
`define TCU_PULSE_SHORT  7'h10
`define TCU_PULSE_LONG   7'h40

// Bus responses
`define TCU_RESP_OKAY    2'h0
`define TCU_RESP_SLVERR  2'h2

`endif

// ==== src/tcu_pkg.sv ====
package tcu_pkg;

    typedef enum logic [1:0] {
        TCU_CC_PULSE16 = 2'b00,
        TCU_CC_PULSE64 = 2'b01,
        TCU_CC_PWM     = 2'b10,
        TCU_CC_TOGGLE  = 2'b11
    } tcu_compare_output_select_t;

    typedef struct packed {
        logic       en;
        logic [2:0] cs;
        tcu_compare_output_select_t compare_output_select;
        logic       terminal_output_select;
        logic       run;
    } tcu_cfg1_t;

    typedef struct packed {
        logic ientc;
        logic iencc;
        logic qecen;
        logic cptclr;
        logic xcren;
        logic xcfen;
    } tcu_cfg3_t;

    typedef struct packed {
        logic tc;
        logic cc;
    } tcu_evt_t;

endpackage : tcu_pkg

// ==== src/tcu_top.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tcu_regs.svh"

// Summary of operation
// - Timer is a 16-bit up-counter advanced by the timer tick.
// - Tick is system clock divided by 1..128 via three-bit select.
// - Counter starts at zero and reloads to zero after terminal count.
// - Terminal-count event when counter equals active period.
// - Compare-match event when counter equals active compare value.
// - Period and compare are double-buffered, taken at period end.
// - Both events drive interrupt flags and output pins.
// - Terminal output is a pulse of 16 or 64 ticks; compare output is a 16 or 64 tick pulse, a toggle or PWM.
// - PWM mode: compare output low below compare, high at or above.
// - Two capture registers, each latches counter on its own event.
// - Captures from external edge, quadrature decoder or software.
// - Optional counter clear on capture event.
// - Disabled: counter and captures zero, event outputs low.
// - Counter advances only when enable and run are both set.
// - Period locations read back the live counter.
// - Flags set by events; software clears by writing zero to CFG2 or one to STAT.
module tcu_top
    import tcu_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              external_capture_input,
    input  wire logic              quadrature_decoder,
    output logic                   terminal_count_event,
    output logic                   compare_match_event,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////////
    tcu_cfg1_t         cfg1_r;
    tcu_cfg3_t         cfg3_r;
    logic              tcpol_r;
    logic              ccpol_r;
    tcu_evt_t          flag_r;
    tcu_evt_t          mask_r;
    logic [15:0]       timer_count_value_r;
    logic [15:0]       prd_buf_r;
    logic [15:0]       prd_act_r;
    logic [7:0]        prd_hi_r;
    logic [15:0]       cmp_buf_r;
    logic [15:0]       cmp_act_r;
    logic [7:0]        cmp_hi_r;
    logic [15:0]       capture_value_rise_r;
    logic [15:0]       capture_value_fall_r;
    logic [6:0]        presc_r;
    logic [6:0]        tc_left_r;
    logic [6:0]        cc_left_r;
    logic              cc_tgl_r;
    logic              ext_prev_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic              aw_hold_r;
    logic [7:0]        w_data_r;
    logic              w_lane_r;
    logic              w_hold_r;

    logic [15:0]       wr_idx;
    logic [15:0]       rd_idx;
    logic              wr_go;
    logic              wr_cfg1;
    logic              wr_cfg2;
    logic              wr_cfg3;
    logic              wr_stat;
    logic              rst_wr;
    logic              running;
    logic [6:0]        presc_mask;
    logic              timer_tick;
    tcu_evt_t          hit;
    logic              cap_rise_ev;
    logic              cap_fall_ev;
    logic              cnt_clr;
    logic              period_end;
    logic              cc_level;
    logic [7:0]        rd_val;

    function automatic logic is_mapped(input logic [15:0] idx);
        is_mapped = (idx == `TCU_IDX_CFG1) || (idx == `TCU_IDX_CFG2) || (idx == `TCU_IDX_CFG3) ||
                    (idx == `TCU_IDX_PRDL) || (idx == `TCU_IDX_PRDH) || (idx == `TCU_IDX_CMPL) ||
                    (idx == `TCU_IDX_CMPH) || (idx == `TCU_IDX_STAT) || (idx == `TCU_IDX_MASK) ||
                    (idx == `TCU_IDX_CPRL) || (idx == `TCU_IDX_CPRH) || (idx == `TCU_IDX_CPFL) ||
                    (idx == `TCU_IDX_CPFH);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data held until both are in
    assign wr_idx  = 16'(aw_addr_r[ADDR_W-1:2]);
    assign wr_go   = aw_hold_r && w_hold_r && !s_axi_bvalid && w_lane_r;
    assign wr_cfg1 = wr_go && (wr_idx == `TCU_IDX_CFG1);
    assign wr_cfg2 = wr_go && (wr_idx == `TCU_IDX_CFG2);
    assign wr_cfg3 = wr_go && (wr_idx == `TCU_IDX_CFG3);
    assign wr_stat = wr_go && (wr_idx == `TCU_IDX_STAT);
    assign rst_wr  = wr_cfg2 && w_data_r[`TCU_CFG2_RSTTC];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TCU_RESP_OKAY;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= 8'h00;
            w_lane_r      <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                aw_hold_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata[7:0];
                w_lane_r     <= s_axi_wstrb[0];
                w_hold_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(wr_idx) ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: one cycle from address handshake to data
    assign rd_idx = 16'(s_axi_araddr[ADDR_W-1:2]);

    always_comb begin
        rd_val = 8'h00;
        unique case (rd_idx)
            `TCU_IDX_CFG1: rd_val = {cfg1_r.en, cfg1_r.cs, cfg1_r.compare_output_select, cfg1_r.terminal_output_select, running};
            `TCU_IDX_CFG2: rd_val = {4'h0, tcpol_r, ccpol_r, flag_r.tc, flag_r.cc};
            `TCU_IDX_CFG3: rd_val = {cfg3_r, 2'b00};
            `TCU_IDX_PRDL: rd_val = timer_count_value_r[7:0];
            `TCU_IDX_PRDH: rd_val = timer_count_value_r[15:8];
            `TCU_IDX_CMPL: rd_val = cmp_buf_r[7:0];
            `TCU_IDX_CMPH: rd_val = cmp_buf_r[15:8];
            `TCU_IDX_STAT: rd_val = {6'h00, flag_r.tc, flag_r.cc};
            `TCU_IDX_MASK: rd_val = {6'h00, mask_r.tc, mask_r.cc};
            `TCU_IDX_CPRL: rd_val = capture_value_rise_r[7:0];
            `TCU_IDX_CPRH: rd_val = capture_value_rise_r[15:8];
            `TCU_IDX_CPFL: rd_val = capture_value_fall_r[7:0];
            `TCU_IDX_CPFH: rd_val = capture_value_fall_r[15:8];
            default:       rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TCU_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_val};
                s_axi_rresp   <= is_mapped(rd_idx) ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg1_r  <= tcu_cfg1_t'(`TCU_CFG_RST);
            cfg3_r  <= tcu_cfg3_t'(6'h00);
            tcpol_r <= 1'b0;
            ccpol_r <= 1'b0;
            mask_r  <= tcu_evt_t'(2'b00);
        end else if (ce) begin
            if (wr_cfg1) begin
                cfg1_r <= tcu_cfg1_t'(w_data_r);
            end else if (rst_wr) begin
                cfg1_r.run <= 1'b0; // Reset command leaves the counter stopped
            end
            if (wr_cfg2) begin
                tcpol_r <= w_data_r[`TCU_CFG2_TCPOL];
                ccpol_r <= w_data_r[`TCU_CFG2_CCPOL];
            end
            if (wr_cfg3) begin
                cfg3_r <= tcu_cfg3_t'(w_data_r[7:2]);
            end
            if (wr_go && (wr_idx == `TCU_IDX_MASK)) begin
                mask_r <= tcu_evt_t'(w_data_r[1:0]);
            end
        end
    end

    // Double buffers; low byte commits the pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prd_hi_r  <= 8'h00;
            prd_buf_r <= `TCU_VAL_RST;
            cmp_hi_r  <= 8'h00;
            cmp_buf_r <= `TCU_VAL_RST;
        end else if (ce) begin
            if (wr_go && (wr_idx == `TCU_IDX_PRDH)) prd_hi_r <= w_data_r;
            if (wr_go && (wr_idx == `TCU_IDX_PRDL)) prd_buf_r <= {prd_hi_r, w_data_r};
            if (wr_go && (wr_idx == `TCU_IDX_CMPH)) cmp_hi_r <= w_data_r;
            if (wr_go && (wr_idx == `TCU_IDX_CMPL)) cmp_buf_r <= {cmp_hi_r, w_data_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter
    assign running    = cfg1_r.en && cfg1_r.run;
    assign presc_mask = 7'((8'h01 << cfg1_r.cs) - 8'h01);
    assign timer_tick = running && ((presc_r & presc_mask) == presc_mask);
    assign hit.tc     = timer_tick && (timer_count_value_r == prd_act_r);
    assign hit.cc     = timer_tick && (timer_count_value_r == cmp_act_r);
    assign cap_rise_ev = cfg1_r.en && ((cfg3_r.xcren && external_capture_input && !ext_prev_r) ||
                         (cfg3_r.qecen && quadrature_decoder) ||
                         (wr_cfg3 && w_data_r[`TCU_CFG3_SWCR]));
    assign cap_fall_ev = cfg1_r.en && ((cfg3_r.xcfen && !external_capture_input && ext_prev_r) ||
                         (wr_cfg3 && w_data_r[`TCU_CFG3_SWCF]));
    assign cnt_clr    = cfg1_r.en && (rst_wr || (cfg3_r.cptclr && (cap_rise_ev || cap_fall_ev)));
    assign period_end = hit.tc && !cnt_clr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_r <= 7'h00;
        end else if (ce) begin
            presc_r <= running ? presc_r + 7'h01 : 7'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count_value_r <= `TCU_VAL_RST;
        end else if (ce) begin
            if (!cfg1_r.en || cnt_clr) begin
                timer_count_value_r <= 16'h0000;
            end else if (timer_tick) begin
                timer_count_value_r <= period_end ? 16'h0000 : timer_count_value_r + 16'h0001;
            end
        end
    end

    // Active values follow the buffers directly while disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prd_act_r <= `TCU_VAL_RST;
            cmp_act_r <= `TCU_VAL_RST;
        end else if (ce) begin
            if (!cfg1_r.en || period_end) begin
                prd_act_r <= prd_buf_r;
                cmp_act_r <= cmp_buf_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Captures
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev_r           <= 1'b0;
            capture_value_rise_r <= `TCU_VAL_RST;
            capture_value_fall_r <= `TCU_VAL_RST;
        end else if (ce) begin
            ext_prev_r <= external_capture_input;
            if (!cfg1_r.en || rst_wr) begin
                capture_value_rise_r <= 16'h0000;
                capture_value_fall_r <= 16'h0000;
            end else begin
                if (cap_rise_ev) capture_value_rise_r <= timer_count_value_r;
                if (cap_fall_ev) capture_value_fall_r <= timer_count_value_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event outputs; registered one cycle behind the tick counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tc_left_r <= 7'h00;
            cc_left_r <= 7'h00;
            cc_tgl_r  <= 1'b0;
        end else if (ce) begin
            if (!cfg1_r.en) begin
                tc_left_r <= 7'h00;
                cc_left_r <= 7'h00;
                cc_tgl_r  <= 1'b0;
            end else begin
                if (hit.tc) begin
                    tc_left_r <= cfg1_r.terminal_output_select ? `TCU_PULSE_LONG : `TCU_PULSE_SHORT;
                end else if (timer_tick && tc_left_r != 7'h00) begin
                    tc_left_r <= tc_left_r - 7'h01;
                end
                if (hit.cc) begin
                    cc_left_r <= (cfg1_r.compare_output_select == TCU_CC_PULSE64) ? `TCU_PULSE_LONG : `TCU_PULSE_SHORT;
                    cc_tgl_r  <= !cc_tgl_r;
                end else if (timer_tick && cc_left_r != 7'h00) begin
                    cc_left_r <= cc_left_r - 7'h01;
                end
            end
        end
    end

    always_comb begin
        unique case (cfg1_r.compare_output_select)
            TCU_CC_PULSE16, TCU_CC_PULSE64: cc_level = (cc_left_r != 7'h00);
            TCU_CC_PWM:                     cc_level = (timer_count_value_r >= cmp_act_r);
            TCU_CC_TOGGLE:                  cc_level = cc_tgl_r;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            terminal_count_event <= 1'b0;
            compare_match_event  <= 1'b0;
        end else if (ce) begin
            terminal_count_event <= cfg1_r.en && ((tc_left_r != 7'h00) ^ tcpol_r);
            compare_match_event  <= cfg1_r.en && (cc_level ^ ccpol_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: event set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= tcu_evt_t'(2'b00);
            irq    <= 1'b0;
        end else if (ce) begin
            flag_r.tc <= hit.tc || (flag_r.tc && !(wr_cfg2 && !w_data_r[`TCU_CFG2_TCF]) &&
                         !(wr_stat && w_data_r[`TCU_CFG2_TCF]));
            flag_r.cc <= hit.cc || (flag_r.cc && !(wr_cfg2 && !w_data_r[`TCU_CFG2_CCF]) &&
                         !(wr_stat && w_data_r[`TCU_CFG2_CCF]));
            irq <= (flag_r.tc && mask_r.tc && cfg3_r.ientc) ||
                   (flag_r.cc && mask_r.cc && cfg3_r.iencc);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    disabled_hold_a: assert property (
        ce && !cfg1_r.en |=> timer_count_value_r == 16'h0000 && capture_value_rise_r == 16'h0000 &&
            capture_value_fall_r == 16'h0000 && !terminal_count_event && !compare_match_event)
        else $error("disabled timer not cleared");
    count_step_a: assert property (
        ce && timer_tick && !cnt_clr && !hit.tc |=> timer_count_value_r == $past(timer_count_value_r) + 16'h0001)
        else $error("counter did not advance by one");
    reload_zero_a: assert property (
        ce && period_end |=> timer_count_value_r == 16'h0000)
        else $error("counter did not reload to zero");
    stopped_hold_a: assert property (
        ce && cfg1_r.en && !cfg1_r.run && !cnt_clr |=> $stable(timer_count_value_r))
        else $error("stopped counter moved");
    tick_div_a: assert property (
        timer_tick && cfg1_r.cs == 3'h5 |-> presc_r[4:0] == 5'h1F)
        else $error("tick rate wrong for divide by 32");
    shadow_load_a: assert property (
        ce && cfg1_r.en && !period_end |=> $stable(prd_act_r) && $stable(cmp_act_r))
        else $error("active value changed mid period");
    tc_flag_a: assert property (
        ce && hit.tc |=> flag_r.tc)
        else $error("terminal flag not set");
    tc_pulse_a: assert property (
        ce && cfg1_r.en && hit.tc && !cfg1_r.terminal_output_select && !tcpol_r && !rst_wr && !wr_cfg1
            |=> tc_left_r == 7'h10 ##1 terminal_count_event)
        else $error("short terminal pulse not started");
    pwm_level_a: assert property (
        ce && cfg1_r.en && cfg1_r.compare_output_select == TCU_CC_PWM && !ccpol_r
            |=> compare_match_event == ($past(timer_count_value_r) >= $past(cmp_act_r)))
        else $error("pwm level wrong");
    capture_latch_a: assert property (
        ce && cap_rise_ev && !rst_wr |=> capture_value_rise_r == $past(timer_count_value_r))
        else $error("rise capture missed count");
    capture_clear_a: assert property (
        ce && cfg1_r.en && cfg3_r.cptclr && cap_fall_ev |=> timer_count_value_r == 16'h0000)
        else $error("capture did not clear counter");
    irq_level_a: assert property (
        ce && flag_r.cc && mask_r.cc && cfg3_r.iencc |=> irq)
        else $error("interrupt not raised");

endmodule : tcu_top

// ==== sim/tcu_pin_model.sv ====
`timescale 1ns/1ps

// Far side of the capture pins: a GPIO level and a decoder strobe
module tcu_pin_model (
    input  wire logic aclk,
    output logic      ext_pin,
    output logic      qd_pin
);
    initial begin
        ext_pin = 1'b0;
        qd_pin = 1'b0;
    end
    // Pin level is held between edges; the design detects the change itself
    task automatic set_ext(input logic v);
        @(posedge aclk);
        ext_pin <= v;
    endtask : set_ext
    // Exactly one cycle high, since a longer level would capture again on every cycle it stays high
    task automatic pulse_qd();
        @(posedge aclk);
        qd_pin <= 1'b1;
        @(posedge aclk);
        qd_pin <= 1'b0;
    endtask : pulse_qd
endmodule : tcu_pin_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "tcu_regs.svh"

module tb_top;
    typedef struct packed {logic [1:0] rs; logic [7:0] lo; logic [7:0] hi;} tcu_exp_t;
    logic        aclk, aresetn = 1'b0, ce = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_rvalid, irq, seen_tc = 1'b0, seen_cc = 1'b0;
    logic        external_capture_input, quadrature_decoder, terminal_count_event, compare_match_event;
    logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h22;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  cv, cf;
    tcu_exp_t    exp_q[$];
    int          mismatches = 0, total_checks = 0, cycles = 0;

    tcu_top #(.ADDR_W(18)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_capture_input, .quadrature_decoder, .terminal_count_event, .compare_match_event, .irq);
    tcu_pin_model pins (.aclk, .ext_pin(external_capture_input), .qd_pin(quadrature_decoder));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic cmp_bit(input logic a, input logic x);
        total_checks++;
        if (a !== x) bad("output level");
    endtask : cmp_bit
    // Counts cannot be pinned to a cycle over the bus, so reads carry a window
    task automatic cmp_rd();
        tcu_exp_t e;
        total_checks++;
        if (exp_q.size() == 0) begin
            bad("unexpected read");
            return;
        end
        e = exp_q.pop_front();
        if (s_axi_rresp !== e.rs || s_axi_rdata[31:8] !== 24'h0 || ^s_axi_rdata[7:0] === 1'bx
            || s_axi_rdata[7:0] < e.lo || s_axi_rdata[7:0] > e.hi) bad("read data or response");
    endtask : cmp_rd
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] st = 4'hF);
        @(posedge aclk);
        void'(xs());
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {rnd[23:0], d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] lo, input logic [7:0] hi,
                      input logic [1:0] rs = `TCU_RESP_OKAY);
        exp_q.push_back('{rs, lo, hi});
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (terminal_count_event === 1'b1) seen_tc <= 1'b1;
        if (compare_match_event === 1'b1) seen_cc <= 1'b1;
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp_rd();
        if (cycles == 30000) begin
            bad("timeout");
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TCU_IDX_CFG1, 8'h00, 8'h00);
        rd(16'hA053, 8'h00, 8'h00, `TCU_RESP_SLVERR);
        done("reset");
        wr(`TCU_IDX_PRDH, 8'hFF);
        wr(`TCU_IDX_PRDL, 8'hFF);
        for (int cs = 0; cs < 8; cs++) begin
            cf = {1'b1, 3'(cs), 4'h0};
            wr(`TCU_IDX_CFG2, 8'h80);
            wr(`TCU_IDX_CFG1, cf);
            rd(`TCU_IDX_PRDL, 8'h00, 8'h00);
            wr(`TCU_IDX_CFG1, cf | 8'h01);
            repeat (64 << cs) @(posedge aclk);
            wr(`TCU_IDX_CFG1, cf);
            rd(`TCU_IDX_PRDL, 8'd63, 8'd70);
            rd(`TCU_IDX_PRDH, 8'h00, 8'h00);
            rd(`TCU_IDX_CFG1, cf, cf);
        end
        done("prescaler");
        void'(xs());
        cv = {5'h0, rnd[2:0]} + 8'h01;
        wr(`TCU_IDX_CFG1, 8'h00);
        rd(`TCU_IDX_PRDL, 8'h00, 8'h00);
        wr(`TCU_IDX_PRDH, 8'h00);
        wr(`TCU_IDX_PRDL, 8'h09);
        wr(`TCU_IDX_CMPH, 8'h00);
        wr(`TCU_IDX_CMPL, cv);
        wr(`TCU_IDX_CFG3, 8'hC0);
        wr(`TCU_IDX_MASK, 8'h03);
        wr(`TCU_IDX_CFG1, 8'h81);
        repeat (60) @(posedge aclk);
        wr(`TCU_IDX_CFG1, 8'h80);
        rd(`TCU_IDX_CFG2, 8'h03, 8'h03);
        rd(`TCU_IDX_PRDL, 8'h00, 8'h09);
        rd(`TCU_IDX_CMPL, cv, cv);
        cmp_bit(irq, 1'b1);
        cmp_bit(seen_tc && seen_cc, 1'b1);
        wr(`TCU_IDX_CFG2, 8'h00);
        rd(`TCU_IDX_CFG2, 8'h00, 8'h00);
        wr(`TCU_IDX_MASK, 8'h00);
        wr(`TCU_IDX_CFG1, 8'h81);
        repeat (20) @(posedge aclk);
        wr(`TCU_IDX_CFG1, 8'h80);
        wr(`TCU_IDX_MASK, 8'h03, 4'h0);
        cmp_bit(irq, 1'b0);
        wr(`TCU_IDX_STAT, 8'h03);
        rd(`TCU_IDX_STAT, 8'h00, 8'h00);
        done("events");
        // PWM with the counter parked at zero, below the compare value cv (1 to 8)
        wr(`TCU_IDX_CFG1, 8'h00);
        wr(`TCU_IDX_CFG1, 8'h88);
        repeat (2) @(posedge aclk);
        cmp_bit(compare_match_event, 1'b0);
        wr(`TCU_IDX_CFG2, 8'h04);
        repeat (2) @(posedge aclk);
        cmp_bit(compare_match_event, 1'b1);
        wr(`TCU_IDX_CFG1, 8'h89);
        repeat (30) @(posedge aclk);
        wr(`TCU_IDX_CFG1, 8'h88);
        done("pwm");
        wr(`TCU_IDX_CFG1, 8'h00);
        wr(`TCU_IDX_PRDH, 8'hFF);
        wr(`TCU_IDX_PRDL, 8'hFF);
        wr(`TCU_IDX_CFG3, 8'h0C);
        wr(`TCU_IDX_CFG1, 8'h81);
        repeat (40) @(posedge aclk);
        pins.set_ext(1'b1);
        repeat (20) @(posedge aclk);
        pins.set_ext(1'b0);
        repeat (5) @(posedge aclk);
        wr(`TCU_IDX_CFG1, 8'h80);
        rd(`TCU_IDX_CPRL, 8'd40, 8'd48);
        rd(`TCU_IDX_CPFL, 8'd60, 8'd69);
        wr(`TCU_IDX_CFG2, 8'h80);
        wr(`TCU_IDX_CFG3, 8'h30);
        wr(`TCU_IDX_CFG1, 8'h81);
        repeat (30) @(posedge aclk);
        pins.pulse_qd();
        repeat (10) @(posedge aclk);
        wr(`TCU_IDX_CFG1, 8'h80);
        rd(`TCU_IDX_CPRL, 8'd29, 8'd37);
        rd(`TCU_IDX_PRDL, 8'd9, 8'd16);
        wr(`TCU_IDX_CFG3, 8'h01);
        rd(`TCU_IDX_CPFL, 8'd9, 8'd16);
        wr(`TCU_IDX_CFG1, 8'h00);
        rd(`TCU_IDX_CPRL, 8'h00, 8'h00);
        rd(`TCU_IDX_CPFL, 8'h00, 8'h00);
        cmp_bit(terminal_count_event || compare_match_event, 1'b0);
        done("capture");
        end_of_test();
    end
endmodule : tb_top
